// ===== vltx_pkg.sv
package vltx_pkg;

  // Register offsets on the configuration bus
  localparam logic [7:0] OFS_APPLY     = 8'h0a;
  localparam logic [7:0] OFS_LINK_CTRL = 8'h0b;
  localparam logic [7:0] OFS_SWING     = 8'h0c;

  // Field positions, link control register
  localparam int EDGE_RATE_LSB = 6;
  localparam int LINK_TYPE_BIT = 5;
  localparam int TERM_LSB      = 3;
  localparam int RATIO_BIT     = 1;
  localparam int TRAIN_BIT     = 0;

  // Field positions, swing and emphasis register
  localparam int DSWING_LSB = 5;
  localparam int CSWING_LSB = 2;
  localparam int DEEMPH_LSB = 0;

  // Field position, apply register
  localparam int APPLY_BIT = 2;

  // Reset values
  localparam logic [1:0] EDGE_RATE_RST = 2'h0;
  localparam logic       LINK_TYPE_RST = 1'h0;
  localparam logic [1:0] TERM_RST      = 2'h0;
  localparam logic       RATIO_RST     = 1'h0;
  localparam logic       TRAIN_RST     = 1'h0;
  localparam logic [2:0] DSWING_RST    = 3'h0;
  localparam logic [2:0] CSWING_RST    = 3'h0;
  localparam logic [1:0] DEEMPH_RST    = 2'h0;

  // Snooped sink register: write address byte, offset, bit
  localparam logic [7:0] SNOOP_ADDR_BYTE = 8'ha8;
  localparam logic [7:0] SNOOP_OFFSET    = 8'h20;
  localparam int         SNOOP_BIT       = 1;

  // Arbitrary neutral default for this device's own bus address
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2d;

  // Hot-plug low time before the ratio flag falls back
  localparam int unsigned CLK_FREQ_KHZ   = 40000;
  localparam int unsigned HPD_LOW_TIME_MS = 2;
  localparam int unsigned HPD_LOW_CYCLES = HPD_LOW_TIME_MS * CLK_FREQ_KHZ;
  localparam int          HPD_CNT_W      = 20;

  typedef struct packed {
    logic [1:0] edge_rate;
    logic [1:0] termination;
    logic [2:0] data_swing;
    logic [2:0] clock_swing;
    logic [1:0] deemphasis;
  } vltx_lane_cfg_type;

  localparam vltx_lane_cfg_type LANE_CFG_RST =
    '{EDGE_RATE_RST, TERM_RST, DSWING_RST, CSWING_RST, DEEMPH_RST};

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ACK_ADDR,
    ST_OFFSET,
    ST_ACK_OFS,
    ST_WDATA,
    ST_ACK_W,
    ST_RDATA,
    ST_ACK_R
  } vltx_bus_state_type;

endpackage

// ===== vltx_lane_apply.sv
module vltx_lane_apply
  import vltx_pkg::*;
(
  // Clocks and reset
  input  wire logic        link_clk_i,
  input  wire logic        reset_i,
  // Transfer from the register side
  input  wire logic        req_tgl_i,
  input  vltx_lane_cfg_type cfg_i,
  input  wire logic        ratio_40_i,
  input  wire logic        full_clock_swing_i,
  // Settings driven to the lanes
  output vltx_lane_cfg_type lane_cfg_o,
  output logic             ack_tgl_o,
  output logic             clock_half_swing_o
);

  logic [1:0] rst_sync_r;
  logic [1:0] req_sync_r;
  logic [1:0] ratio_sync_r;
  logic [1:0] full_sync_r;
  logic       link_rst;
  logic       new_req;

  assign link_rst = rst_sync_r[1];
  assign new_req  = req_sync_r[1] ^ ack_tgl_o;

  // Reset is synchronous, so it must be held for a few link clocks
  always_ff @(posedge link_clk_i) begin
    rst_sync_r   <= {rst_sync_r[0], reset_i};
    req_sync_r   <= {req_sync_r[0], req_tgl_i};
    ratio_sync_r <= {ratio_sync_r[0], ratio_40_i};
    full_sync_r  <= {full_sync_r[0], full_clock_swing_i};
  end

  // Word is stable while the toggle is outstanding
  always_ff @(posedge link_clk_i) begin
    if (link_rst) begin
      lane_cfg_o <= LANE_CFG_RST;
      ack_tgl_o  <= 1'h0;
    end else if (new_req) begin
      lane_cfg_o <= cfg_i;
      ack_tgl_o  <= req_sync_r[1];
    end
  end

  always_ff @(posedge link_clk_i) begin
    if (link_rst) begin
      clock_half_swing_o <= 1'h0;
    end else begin
      clock_half_swing_o <= ratio_sync_r[1] & ~full_sync_r[1];
    end
  end

endmodule // vltx_lane_apply

// ===== vltx_tx_ctrl.sv
module vltx_tx_ctrl
  import vltx_pkg::*;
#(
  parameter logic [6:0]  DEV_ADDR         = DEV_ADDR_DEFAULT,
  parameter int unsigned HPD_LOW_CYCLES_P = HPD_LOW_CYCLES
) (
  // Clocks and reset
  input  wire logic         clock_i,
  input  wire logic         reset_i,
  input  wire logic         link_clk_i,
  // Host configuration bus, open drain data
  input  wire logic         host_scl_i,
  input  wire logic         host_sda_i,
  output logic              host_sda_o,
  output logic              host_sda_oe_o,
  // Source-side bus, watched only
  input  wire logic         source_side_serial_clock_i,
  input  wire logic         source_side_serial_data_i,
  // Pins
  input  wire logic         sink_hotplug_in_i,
  input  wire logic         output_enable_i,
  input  wire logic         config_from_host_i,
  input  wire logic         full_clock_swing_i,
  // Status and settings
  output logic              link_type_dvi_o,
  output logic              clock_ratio_flag_o,
  output logic              training_disable_o,
  output vltx_lane_cfg_type lane_cfg_o,
  output logic              clock_half_swing_o
);

  // Pin synchronisers
  logic [1:0] hs_scl_s_r;
  logic [1:0] hs_sda_s_r;
  logic [1:0] sn_scl_s_r;
  logic [1:0] sn_sda_s_r;
  logic [1:0] hpd_s_r;
  logic [1:0] oe_s_r;
  logic [1:0] cfg_src_s_r;
  logic [1:0] ack_s_r;

  always_ff @(posedge clock_i) begin
    hs_scl_s_r  <= {hs_scl_s_r[0], host_scl_i};
    hs_sda_s_r  <= {hs_sda_s_r[0], host_sda_i};
    sn_scl_s_r  <= {sn_scl_s_r[0], source_side_serial_clock_i};
    sn_sda_s_r  <= {sn_sda_s_r[0], source_side_serial_data_i};
    hpd_s_r     <= {hpd_s_r[0], sink_hotplug_in_i};
    oe_s_r      <= {oe_s_r[0], output_enable_i};
    cfg_src_s_r <= {cfg_src_s_r[0], config_from_host_i};
  end

  // Host bus slave
  logic               hs_scl_d_r;
  logic               hs_sda_d_r;
  logic               hs_scl;
  logic               hs_sda;
  logic               hs_start;
  logic               hs_stop;
  logic               hs_rise;
  logic               hs_fall;
  vltx_bus_state_type state_r;
  logic [3:0]         bit_cnt_r;
  logic [7:0]         shreg_r;
  logic [7:0]         ofs_r;
  logic               rw_r;
  logic               wr_stb_r;
  logic [7:0]         wr_data_r;
  logic [7:0]         rd_byte;

  assign hs_scl   = hs_scl_s_r[1];
  assign hs_sda   = hs_sda_s_r[1];
  assign hs_start = hs_scl & hs_scl_d_r & hs_sda_d_r & ~hs_sda;
  assign hs_stop  = hs_scl & hs_scl_d_r & ~hs_sda_d_r & hs_sda;
  assign hs_rise  = hs_scl & ~hs_scl_d_r;
  assign hs_fall  = ~hs_scl & hs_scl_d_r;

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      hs_scl_d_r <= 1'h1;
      hs_sda_d_r <= 1'h1;
      host_sda_o <= 1'h0;
    end else begin
      hs_scl_d_r <= hs_scl;
      hs_sda_d_r <= hs_sda;
      host_sda_o <= 1'h0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      state_r       <= ST_IDLE;
      bit_cnt_r     <= 4'h0;
      shreg_r       <= 8'h00;
      ofs_r         <= 8'h00;
      rw_r          <= 1'h0;
      wr_stb_r      <= 1'h0;
      wr_data_r     <= 8'h00;
      host_sda_oe_o <= 1'h0;
    end else begin
      wr_stb_r <= 1'h0;
      if (hs_start) begin
        state_r       <= ST_ADDR;
        bit_cnt_r     <= 4'h0;
        host_sda_oe_o <= 1'h0;
      end else if (hs_stop) begin
        state_r       <= ST_IDLE;
        host_sda_oe_o <= 1'h0;
      end else begin
        case (state_r)
          ST_ADDR, ST_OFFSET, ST_WDATA: begin
            if (hs_rise) begin
              shreg_r   <= {shreg_r[6:0], hs_sda};
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end else if (hs_fall && bit_cnt_r == 4'h8) begin
              bit_cnt_r <= 4'h0;
              if (state_r == ST_ADDR) begin
                if (shreg_r[7:1] == DEV_ADDR) begin
                  rw_r          <= shreg_r[0];
                  host_sda_oe_o <= 1'h1;
                  state_r       <= ST_ACK_ADDR;
                end else begin
                  state_r <= ST_IDLE;
                end
              end else if (state_r == ST_OFFSET) begin
                ofs_r         <= shreg_r;
                host_sda_oe_o <= 1'h1;
                state_r       <= ST_ACK_OFS;
              end else begin
                wr_stb_r      <= 1'h1;
                wr_data_r     <= shreg_r;
                host_sda_oe_o <= 1'h1;
                state_r       <= ST_ACK_W;
              end
            end
          end
          ST_ACK_ADDR: begin
            if (hs_fall) begin
              if (rw_r) begin
                shreg_r       <= rd_byte;
                host_sda_oe_o <= ~rd_byte[7];
                state_r       <= ST_RDATA;
              end else begin
                host_sda_oe_o <= 1'h0;
                state_r       <= ST_OFFSET;
              end
            end
          end
          ST_ACK_OFS: begin
            if (hs_fall) begin
              host_sda_oe_o <= 1'h0;
              state_r       <= ST_WDATA;
            end
          end
          ST_ACK_W: begin
            if (hs_fall) begin
              host_sda_oe_o <= 1'h0;
              ofs_r         <= ofs_r + 8'h01;
              state_r       <= ST_WDATA;
            end
          end
          ST_RDATA: begin
            if (hs_rise) begin
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end else if (hs_fall) begin
              if (bit_cnt_r == 4'h8) begin
                bit_cnt_r     <= 4'h0;
                host_sda_oe_o <= 1'h0;
                ofs_r         <= ofs_r + 8'h01;
                state_r       <= ST_ACK_R;
              end else begin
                shreg_r       <= {shreg_r[6:0], 1'h0};
                host_sda_oe_o <= ~shreg_r[6];
              end
            end
          end
          ST_ACK_R: begin
            // Master not-acknowledge ends the read burst
            if (hs_rise && hs_sda) begin
              state_r <= ST_IDLE;
            end else if (hs_fall) begin
              shreg_r       <= rd_byte;
              host_sda_oe_o <= ~rd_byte[7];
              state_r       <= ST_RDATA;
            end
          end
          default: begin
            state_r <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // Staged settings; edge rate and link type writable only while config_from_host_i is high, the rest at any time
  logic [1:0] edge_rate_q_r;
  logic [1:0] term_r;
  logic [2:0] dswing_r;
  logic [2:0] cswing_r;
  logic [1:0] deemph_r;
  logic       commit_r;
  logic       host_cfg;

  assign host_cfg = cfg_src_s_r[1];

  always_comb begin
    case (ofs_r)
      OFS_LINK_CTRL: rd_byte = {edge_rate_q_r, link_type_dvi_o, term_r, 1'h0,
                                clock_ratio_flag_o, training_disable_o};
      OFS_SWING:     rd_byte = {dswing_r, cswing_r, deemph_r};
      default:       rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      edge_rate_q_r      <= EDGE_RATE_RST;
      link_type_dvi_o    <= LINK_TYPE_RST;
      term_r             <= TERM_RST;
      training_disable_o <= TRAIN_RST;
      dswing_r           <= DSWING_RST;
      cswing_r           <= CSWING_RST;
      deemph_r           <= DEEMPH_RST;
      commit_r           <= 1'h0;
    end else begin
      commit_r <= 1'h0;
      if (wr_stb_r) begin
        case (ofs_r)
          OFS_LINK_CTRL: begin
            if (host_cfg) begin
              edge_rate_q_r   <= wr_data_r[EDGE_RATE_LSB +: 2];
              link_type_dvi_o <= wr_data_r[LINK_TYPE_BIT];
            end
            term_r             <= wr_data_r[TERM_LSB +: 2];
            training_disable_o <= wr_data_r[TRAIN_BIT];
          end
          OFS_SWING: begin
            dswing_r <= wr_data_r[DSWING_LSB +: 3];
            cswing_r <= wr_data_r[CSWING_LSB +: 3];
            deemph_r <= wr_data_r[DEEMPH_LSB +: 2];
          end
          OFS_APPLY: begin
            commit_r <= wr_data_r[APPLY_BIT];
          end
          default: begin
            commit_r <= 1'h0;
          end
        endcase
      end
    end
  end

  // Source-side snooper, passive: never acknowledges or drives
  logic       sn_scl_d_r;
  logic       sn_sda_d_r;
  logic       sn_start;
  logic       sn_stop;
  logic       sn_rise;
  logic [3:0] sn_cnt_r;
  logic [1:0] sn_byte_r;
  logic [7:0] sn_sh_r;
  logic       sn_hit_r;
  logic       snoop_stb_r;
  logic       snoop_bit_r;

  assign sn_start = sn_scl_s_r[1] & sn_scl_d_r & sn_sda_d_r & ~sn_sda_s_r[1];
  assign sn_stop  = sn_scl_s_r[1] & sn_scl_d_r & ~sn_sda_d_r & sn_sda_s_r[1];
  assign sn_rise  = sn_scl_s_r[1] & ~sn_scl_d_r;

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      sn_scl_d_r  <= 1'h1;
      sn_sda_d_r  <= 1'h1;
      sn_cnt_r    <= 4'h0;
      sn_byte_r   <= 2'h0;
      sn_sh_r     <= 8'h00;
      sn_hit_r    <= 1'h0;
      snoop_stb_r <= 1'h0;
      snoop_bit_r <= 1'h0;
    end else begin
      sn_scl_d_r  <= sn_scl_s_r[1];
      sn_sda_d_r  <= sn_sda_s_r[1];
      snoop_stb_r <= 1'h0;
      if (sn_start) begin
        sn_cnt_r  <= 4'h0;
        sn_byte_r <= 2'h0;
        sn_hit_r  <= 1'h1;
      end else if (sn_stop) begin
        sn_hit_r <= 1'h0;
      end else if (sn_rise) begin
        if (sn_cnt_r == 4'h8) begin
          // Ninth clock is the acknowledge slot; the byte is complete
          sn_cnt_r <= 4'h0;
          if (sn_byte_r != 2'h3) begin
            sn_byte_r <= sn_byte_r + 2'h1;
          end
          case (sn_byte_r)
            2'h0: sn_hit_r <= sn_hit_r & (sn_sh_r == SNOOP_ADDR_BYTE);
            2'h1: sn_hit_r <= sn_hit_r & (sn_sh_r == SNOOP_OFFSET);
            2'h2: begin
              snoop_stb_r <= sn_hit_r;
              snoop_bit_r <= sn_sh_r[SNOOP_BIT];
              sn_hit_r    <= 1'h0;
            end
            default: sn_hit_r <= 1'h0;
          endcase
        end else begin
          sn_sh_r  <= {sn_sh_r[6:0], sn_sda_s_r[1]};
          sn_cnt_r <= sn_cnt_r + 4'h1;
        end
      end
    end
  end

  // Hot-plug low timer, saturating; once saturated the clear pulses on every other cycle
  logic [HPD_CNT_W-1:0] hpd_cnt_r;
  logic                 hpd_clear_r;

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      hpd_cnt_r   <= '0;
      hpd_clear_r <= 1'h0;
    end else begin
      hpd_clear_r <= 1'h0;
      if (hpd_s_r[1]) begin
        hpd_cnt_r <= '0;
      end else if (hpd_cnt_r != HPD_CNT_W'(HPD_LOW_CYCLES_P)) begin
        hpd_cnt_r <= hpd_cnt_r + 1'b1;
      end else if (!hpd_clear_r) begin
        hpd_clear_r <= 1'h1;
      end
    end
  end

  // Flag: 1 selects the one-fortieth clock; a snooped write wins over the timeout
  logic hpd_fired_r;

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      clock_ratio_flag_o <= RATIO_RST;
      hpd_fired_r        <= 1'h0;
    end else begin
      hpd_fired_r <= hpd_s_r[1] ? 1'h0 : (hpd_fired_r | hpd_clear_r);
      if (training_disable_o) begin
        clock_ratio_flag_o <= 1'h1;
      end else if (snoop_stb_r) begin
        clock_ratio_flag_o <= snoop_bit_r;
      end else if (hpd_clear_r && !hpd_fired_r) begin
        clock_ratio_flag_o <= RATIO_RST;
      end
    end
  end

  // Commit handshake toward the link domain
  vltx_lane_cfg_type staged;
  vltx_lane_cfg_type xfer_cfg_r;
  logic              req_tgl_r;
  logic              busy_r;
  logic              again_r;
  logic              lanes_idle;
  logic              ack_tgl;

  assign staged     = '{edge_rate_q_r, term_r, dswing_r, cswing_r, deemph_r};
  // Lanes not driving: settings may follow the registers directly
  assign lanes_idle = ~oe_s_r[1] | ~hpd_s_r[1];

  always_ff @(posedge clock_i) begin
    ack_s_r <= {ack_s_r[0], ack_tgl};
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      xfer_cfg_r <= LANE_CFG_RST;
      req_tgl_r  <= 1'h0;
      busy_r     <= 1'h0;
      again_r    <= 1'h0;
    end else if (!busy_r && (again_r || commit_r || lanes_idle)) begin
      xfer_cfg_r <= staged;
      req_tgl_r  <= ~req_tgl_r;
      busy_r     <= 1'h1;
      again_r    <= 1'h0;
    end else begin
      if (busy_r && ack_s_r[1] == req_tgl_r) begin
        busy_r <= 1'h0;
      end
      if (commit_r) begin
        again_r <= 1'h1;
      end
    end
  end

  vltx_lane_apply u_lane_apply (
    .link_clk_i         (link_clk_i),
    .reset_i            (reset_i),
    .req_tgl_i          (req_tgl_r),
    .cfg_i              (xfer_cfg_r),
    .ratio_40_i         (clock_ratio_flag_o),
    .full_clock_swing_i (full_clock_swing_i),
    .lane_cfg_o         (lane_cfg_o),
    .ack_tgl_o          (ack_tgl),
    .clock_half_swing_o (clock_half_swing_o)
  );

endmodule // vltx_tx_ctrl

// ===== vltx_host_model.sv
module vltx_host_model (
  // Timing reference
  input  wire logic clock_i,
  // Device side of the open-drain data wire
  input  wire logic dev_sda_oe_i,
  // Bus wires as seen by everyone
  output logic      scl_o,
  output logic      sda_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic drive_low;
  // Pulled up: low when either party pulls
  assign sda_o = !(drive_low || dev_sda_oe_i);
  initial begin
    scl_o = 1'b1;
    drive_low = 1'b0;
  end
  // 16 system clocks per half, twice the device minimum
  task automatic half();
    repeat (16) @(negedge clock_i);
  endtask
  // Also serves as repeated start
  task automatic start();
    drive_low = 1'b0;
    half();
    scl_o = 1'b1;
    half();
    drive_low = 1'b1;
    half();
    scl_o = 1'b0;
  endtask
  task automatic stop();
    drive_low = 1'b1;
    half();
    scl_o = 1'b1;
    half();
    drive_low = 1'b0;
    half();
  endtask
  // Eight data clocks MSB first, then the acknowledge slot
  task automatic xfer(input logic [7:0] wr, input logic host_ack,
                      output logic [7:0] rd, output logic slot9);
    for (int i = 7; i >= 0; i--) begin
      drive_low = !wr[i];
      half();
      scl_o = 1'b1;
      rd[i] = sda_o;
      half();
      scl_o = 1'b0;
    end
    drive_low = host_ack;
    half();
    scl_o = 1'b1;
    slot9 = !sda_o;
    half();
    scl_o = 1'b0;
  endtask
endmodule // vltx_host_model

// ===== vltx_tx_ctrl_chk.sv
module vltx_tx_ctrl_chk
  import vltx_pkg::*;
#(
  parameter int unsigned HPD_LOW_CYCLES_P = HPD_LOW_CYCLES
) (
  // Clocks and reset
  input  wire logic clock_i,
  input  wire logic reset_i,
  input  wire logic link_clk_i,
  // Watched pins
  input  wire logic host_scl_i,
  input  wire logic host_sda_o,
  input  wire logic host_sda_oe_o,
  input  wire logic source_side_serial_clock_i,
  input  wire logic sink_hotplug_in_i,
  input  wire logic config_from_host_i,
  input  wire logic full_clock_swing_i,
  input  wire logic link_type_dvi_o,
  input  wire logic clock_ratio_flag_o,
  input  wire logic training_disable_o,
  input  wire logic clock_half_swing_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned low_cnt_r;
  // Saturates so a long unplug never wraps
  always_ff @(posedge clock_i) begin
    if (reset_i || sink_hotplug_in_i) begin
      low_cnt_r <= 32'h0;
    end else if (low_cnt_r < 32'hffff) begin
      low_cnt_r <= low_cnt_r + 32'h1;
    end
  end
  sequence s_strap;
    !config_from_host_i [*3];
  endsequence
  sequence s_half_on;
    (clock_ratio_flag_o && !full_clock_swing_i) [*6];
  endsequence
  sequence s_full_kept;
    full_clock_swing_i [*6];
  endsequence
  sequence s_slow_off;
    !clock_ratio_flag_o [*6];
  endsequence
  property p_train_forces;
    @(posedge clock_i) disable iff (reset_i) training_disable_o |=> clock_ratio_flag_o;
  endproperty
  property p_strap_keeps;
    @(posedge clock_i) disable iff (reset_i) s_strap |-> $stable(link_type_dvi_o);
  endproperty
  property p_half_on;
    @(posedge link_clk_i) disable iff (reset_i) s_half_on |-> clock_half_swing_o;
  endproperty
  property p_full_kept;
    @(posedge link_clk_i) disable iff (reset_i) s_full_kept |-> !clock_half_swing_o;
  endproperty
  property p_slow_off;
    @(posedge link_clk_i) disable iff (reset_i) s_slow_off |-> !clock_half_swing_o;
  endproperty
  property p_unplug_clears;
    @(posedge clock_i) disable iff (reset_i)
      low_cnt_r == HPD_LOW_CYCLES_P + 8 |-> !clock_ratio_flag_o || training_disable_o;
  endproperty
  property p_flag_cause;
    @(posedge clock_i) disable iff (reset_i) $changed(clock_ratio_flag_o)
      |-> training_disable_o || !sink_hotplug_in_i || source_side_serial_clock_i;
  endproperty
  property p_open_drain;
    @(posedge clock_i) disable iff (reset_i) host_sda_oe_o |-> !host_sda_o;
  endproperty
  property p_sda_moves_low;
    @(posedge clock_i) disable iff (reset_i) $changed(host_sda_oe_o) |-> !host_scl_i;
  endproperty
  property p_reset_vals;
    @(posedge clock_i) disable iff (reset_i)
      $fell(reset_i) |-> !link_type_dvi_o && !training_disable_o && !clock_ratio_flag_o;
  endproperty
  a_train_forces: assert property (p_train_forces) else $error("ratio flag not forced");
  a_strap_keeps: assert property (p_strap_keeps) else $error("link type moved in strap");
  a_half_on: assert property (p_half_on) else $error("clock swing not halved");
  a_full_kept: assert property (p_full_kept) else $error("override ignored");
  a_slow_off: assert property (p_slow_off) else $error("halved at 1/10");
  a_unplug_clears: assert property (p_unplug_clears) else $error("flag kept on unplug");
  a_flag_cause: assert property (p_flag_cause) else $error("flag moved without cause");
  a_open_drain: assert property (p_open_drain) else $error("data driven high");
  a_sda_moves_low: assert property (p_sda_moves_low) else $error("data moved, clock high");
  a_reset_vals: assert property (p_reset_vals) else $error("bad reset value");
endmodule // vltx_tx_ctrl_chk

bind vltx_tx_ctrl vltx_tx_ctrl_chk #(.HPD_LOW_CYCLES_P(HPD_LOW_CYCLES_P)) chk_u (
  .clock_i(clock_i), .reset_i(reset_i), .link_clk_i(link_clk_i),
  .host_scl_i(host_scl_i), .host_sda_o(host_sda_o), .host_sda_oe_o(host_sda_oe_o),
  .source_side_serial_clock_i(source_side_serial_clock_i),
  .sink_hotplug_in_i(sink_hotplug_in_i), .config_from_host_i(config_from_host_i),
  .full_clock_swing_i(full_clock_swing_i), .link_type_dvi_o(link_type_dvi_o),
  .clock_ratio_flag_o(clock_ratio_flag_o), .training_disable_o(training_disable_o),
  .clock_half_swing_o(clock_half_swing_o));

// ===== tb.sv
module tb;
  import vltx_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned HPD_P = 50;
  logic              clock_i, link_clk_i, reset_i;
  logic              h_scl, h_sda, s_scl, s_sda, sda_o, sda_oe;
  logic              hpd, oe, cfg_host, full_sw;
  logic              dvi, flag, train, half_sw;
  vltx_lane_cfg_type lane, exp_cfg;
  logic [7:0]        rd;
  int                bad_count = 0;
  int                total_checks = 0;
  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end
  initial begin
    link_clk_i = 1'b0;
    #7;
    forever #15 link_clk_i = ~link_clk_i;
  end
  vltx_host_model h_u (.clock_i(clock_i), .dev_sda_oe_i(sda_oe), .scl_o(h_scl), .sda_o(h_sda));
  vltx_host_model s_u (.clock_i(clock_i), .dev_sda_oe_i(1'b0), .scl_o(s_scl), .sda_o(s_sda));
  vltx_tx_ctrl #(.HPD_LOW_CYCLES_P(HPD_P)) dut_u (
    .clock_i(clock_i), .reset_i(reset_i), .link_clk_i(link_clk_i),
    .host_scl_i(h_scl), .host_sda_i(h_sda), .host_sda_o(sda_o), .host_sda_oe_o(sda_oe),
    .source_side_serial_clock_i(s_scl), .source_side_serial_data_i(s_sda),
    .sink_hotplug_in_i(hpd), .output_enable_i(oe), .config_from_host_i(cfg_host),
    .full_clock_swing_i(full_sw), .link_type_dvi_o(dvi), .clock_ratio_flag_o(flag),
    .training_disable_o(train), .lane_cfg_o(lane), .clock_half_swing_o(half_sw));
  task automatic end_sim();
    if (bad_count == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic reg_wr(input logic [7:0] ofs, input logic [7:0] data);
    logic [7:0] d;
    logic       a0, a1, a2;
    h_u.start();
    h_u.xfer({DEV_ADDR_DEFAULT, 1'b0}, 1'b0, d, a0);
    h_u.xfer(ofs, 1'b0, d, a1);
    h_u.xfer(data, 1'b0, d, a2);
    h_u.stop();
    chk({9'h0, a0, a1, a2}, 12'h007);
  endtask
  task automatic reg_rd(input logic [7:0] ofs, output logic [7:0] data);
    logic [7:0] d;
    logic       a0, a1, a2, a3;
    h_u.start();
    h_u.xfer({DEV_ADDR_DEFAULT, 1'b0}, 1'b0, d, a0);
    h_u.xfer(ofs, 1'b0, d, a1);
    h_u.start();
    h_u.xfer({DEV_ADDR_DEFAULT, 1'b1}, 1'b0, d, a2);
    h_u.xfer(8'hff, 1'b0, data, a3);
    h_u.stop();
    chk({9'h0, a0, a1, a2}, 12'h007);
  endtask
  // Nobody answers on the watched bus; the slot is ignored
  task automatic snoop_wr(input logic [7:0] ofs, input logic [7:0] data);
    logic [7:0] d;
    logic       a;
    s_u.start();
    s_u.xfer(SNOOP_ADDR_BYTE, 1'b0, d, a);
    s_u.xfer(ofs, 1'b0, d, a);
    s_u.xfer(data, 1'b0, d, a);
    s_u.stop();
  endtask
  task automatic wait_cfg(input vltx_lane_cfg_type exp);
    int n;
    n = 0;
    while (lane !== exp && n < 200) begin
      @(negedge clock_i);
      n++;
    end
    chk(lane, exp);
    if (n == 200) begin
      end_sim();
    end
  endtask
  initial begin
    reset_i = 1'b1;
    hpd = 1'b1;
    oe = 1'b1;
    cfg_host = 1'b0;
    full_sw = 1'b0;
    repeat (4) @(negedge clock_i);
    reset_i = 1'b0;
    repeat (8) @(negedge clock_i);
    chk(lane, LANE_CFG_RST);
    chk({dvi, train, flag}, 12'h0);
    reg_rd(OFS_LINK_CTRL, rd);
    chk(rd, 8'h00);
    reg_wr(OFS_LINK_CTRL, 8'hf8);
    reg_rd(OFS_LINK_CTRL, rd);
    chk(rd, 8'h18);
    cfg_host = 1'b1;
    reg_wr(OFS_LINK_CTRL, 8'he6);
    reg_rd(OFS_LINK_CTRL, rd);
    chk(rd, 8'he0);
    chk({dvi, flag}, 12'h2);
    exp_cfg = LANE_CFG_RST;
    for (int i = 0; i < 8; i++) begin
      reg_wr(OFS_SWING, {i[2:0], ~i[2:0], i[1:0]});
      chk(lane, exp_cfg);
      reg_wr(OFS_APPLY, 8'h04);
      exp_cfg = '{2'h3, 2'h0, i[2:0], ~i[2:0], i[1:0]};
      wait_cfg(exp_cfg);
    end
    reg_rd(OFS_SWING, rd);
    chk(rd, 8'he3);
    // Lanes idle: settings follow without a commit
    oe = 1'b0;
    reg_wr(OFS_SWING, 8'h44);
    wait_cfg('{2'h3, 2'h0, 3'h2, 3'h1, 2'h0});
    oe = 1'b1;
    reg_rd(8'h30, rd);
    chk(rd, 8'h00);
    snoop_wr(SNOOP_OFFSET, 8'h02);
    chk(flag, 1'b1);
    repeat (20) @(negedge link_clk_i);
    chk(half_sw, 1'b1);
    full_sw = 1'b1;
    repeat (20) @(negedge link_clk_i);
    chk(half_sw, 1'b0);
    full_sw = 1'b0;
    snoop_wr(8'h21, 8'h00);
    chk(flag, 1'b1);
    snoop_wr(SNOOP_OFFSET, 8'hfd);
    chk(flag, 1'b0);
    snoop_wr(SNOOP_OFFSET, 8'h02);
    hpd = 1'b0;
    repeat (HPD_P - 10) @(negedge clock_i);
    chk(flag, 1'b1);
    repeat (30) @(negedge clock_i);
    chk(flag, 1'b0);
    hpd = 1'b1;
    reg_wr(OFS_LINK_CTRL, 8'h01);
    chk(flag, 1'b1);
    reg_rd(OFS_LINK_CTRL, rd);
    chk(rd, 8'h03);
    hpd = 1'b0;
    repeat (HPD_P + 30) @(negedge clock_i);
    chk(flag, 1'b1);
    hpd = 1'b1;
    end_sim();
  end
endmodule // tb
